// *** verilog/spi_port_pkg.sv ***
// package: register map, field positions, resets and carriers for the serial port
`default_nettype none
package spi_port_pkg;

	// register addresses
	localparam logic [7:0] ADDR_CONFIG   = 8'hA1;
	localparam logic [7:0] ADDR_CLK_RATE = 8'hA2;
	localparam logic [7:0] ADDR_DATA     = 8'hA3;
	localparam logic [7:0] ADDR_CONTROL  = 8'hF8;

	// control register fields
	localparam int CTL_DONE     = 7;
	localparam int CTL_WRITE_COLLISION_FLAG     = 6;
	localparam int CTL_MODE_FAULT_FLAG     = 5;
	localparam int CTL_OVRN     = 4;
	localparam int CTL_SEL_HI   = 3;
	localparam int CTL_SEL_LO   = 2;
	localparam int CTL_TX_EMPTY = 1;
	localparam int CTL_PORT_EN  = 0;

	// config and status register fields
	localparam int CFG_BUSY        = 7;
	localparam int CFG_MASTER      = 6;
	localparam int CFG_PHASE       = 5;
	localparam int CFG_POL         = 4;
	localparam int CFG_SELECTED    = 3;
	localparam int CFG_SEL_PIN     = 2;
	localparam int CFG_SHIFT_EMPTY = 1;
	localparam int CFG_RX_EMPTY    = 0;

	// select mode encodings
	localparam logic [1:0] SEL_MODE_3WIRE = 2'h0;
	localparam logic [1:0] SEL_MODE_4WIRE = 2'h1;

	// reset values
	localparam logic [1:0] SEL_MODE_RESET = 2'h1;
	localparam logic [7:0] BYTE_RESET     = 8'h00;

	// sizes and timing
	localparam int BYTE_BITS        = 8;
	localparam int BIT_CNT_W        = 3;
	localparam int SEL_SETUP_CYCLES = 2;

	// register access request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_t;

endpackage
`default_nettype wire

// *** verilog/spi_link_shift.sv ***
// link-clock side: bit counter and receive shifter clocked by the serial clock
`timescale 1ns/10ps
`default_nettype none
module spi_link_shift
	import spi_port_pkg::*;
#(
	parameter int WIDTH = BYTE_BITS,
	parameter int CNT_W = BIT_CNT_W
) (
	// link clock and resets
	input  wire logic             sck,
	input  wire logic             edge_invert,
	input  wire logic             rst_n,
	input  wire logic             link_rst_n,
	// serial data in
	input  wire logic             mosi,
	// towards the system domain
	output logic [CNT_W-1:0]      cnt_gray,
	output logic [WIDTH-1:0]      rx_word,
	output logic                  done_tog
);
	logic             sample_clk;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic [WIDTH-1:0] rx_shift;

	// latch edge picked from phase and polarity
	assign sample_clk = sck ^ edge_invert;
	assign next_cnt   = cnt + 1'b1;

	// bit counter, gray copy for crossing
	always_ff @(posedge sample_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			cnt      <= '0;
			cnt_gray <= '0;
		end else begin
			cnt      <= next_cnt;
			cnt_gray <= next_cnt ^ (next_cnt >> 1);
		end
	end

	// msb-first receive shifter
	always_ff @(posedge sample_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_shift <= '0;
		end else begin
			rx_shift <= {rx_shift[WIDTH-2:0], mosi};
		end
	end

	// whole byte captured and signalled by toggle
	always_ff @(posedge sample_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_word  <= '0;
			done_tog <= 1'b0;
		end else if (cnt == CNT_W'(WIDTH - 1)) begin
			rx_word  <= {rx_shift[WIDTH-2:0], mosi};
			done_tog <= ~done_tog;
		end
	end

	// byte boundary checks
	byte_wrap_a: assert property (@(posedge sample_clk)
		disable iff (!link_rst_n)
		cnt == CNT_W'(WIDTH - 1) |=> cnt == '0 && done_tog != $past(done_tog))
		else $error("counter wrap without byte done toggle");

endmodule
`default_nettype wire

// *** verilog/spi_port_slave.sv ***
// serial port slave: registers, transmit and receive buffers, flags, pins
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - enabled with master bit clear, port only acts as slave, never starts transfers
// - count serial edges; after 8 bits set done flag, copy byte to receive buffer
// - reading data register returns receive buffer contents
// - data write goes to transmit buffer, moved at once if shifter empty
// - busy shifter reloads from transmit buffer only after last edge of byte
// - select mode 01 uses select pin as input, active low
// - in 4-wire mode bit counter held reset while select pin is high
// - select mode 00 ignores select pin and is always selected
// - in 3-wire mode only port enable toggling resets bit counter
// - four flags request interrupt; only software clears them
// - done flag set at end of every byte in every mode
// - data write with full transmit buffer sets collision, write dropped
// - multi-master with select low sets fault, clears master and port enable
// - byte done with unread receive buffer sets overrun, new byte lost
// - config bit 5 picks latch edge, bit 4 picks clock polarity
// - clock rate register has no effect in slave mode
// - master bit rate limited to half system clock or 12.5 MHz
// - polarity 0 idles clock low, polarity 1 idles high
// - phase 0 centres data on first edge, phase 1 on second
// - busy bit reads 1 while a transfer is in progress
// - shift-empty bit reads 1 when idle and nothing pending; 1 in master
module spi_port_slave
	import spi_port_pkg::*;
#(
	parameter int WIDTH = BYTE_BITS,
	parameter int CNT_W = BIT_CNT_W
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// register access
	input  wire sfr_req_t   sfr_req,
	output logic [7:0]      sfr_rdata,
	// serial pins
	input  wire logic       sck_in,
	input  wire logic       mosi_in,
	input  wire logic       sel_n_in,
	output logic            miso_out,
	output logic            miso_oe,
	// interrupt request
	output logic            irq_req
);
	// software state
	logic             port_en;
	logic             master_en;
	logic             phase;
	logic             pol;
	logic [1:0]       sel_mode;
	logic [7:0]       clk_rate;
	logic             transfer_done_flag;
	logic             write_collision_flag;
	logic             mode_fault_flag;
	logic             receive_overrun_flag;
	// data path
	logic [WIDTH-1:0] tx_buf;
	logic             tx_full;
	logic [WIDTH-1:0] tx_shift;
	logic             shift_loaded;
	logic [WIDTH-1:0] rx_data;
	logic             rx_full;
	// crossings
	logic             sel_meta;
	logic             sel_sync;
	logic             done_meta;
	logic             done_sync;
	logic             done_prev;
	logic [CNT_W-1:0] cnt_meta;
	logic [CNT_W-1:0] cnt_sync;
	logic [CNT_W-1:0] link_cnt_gray;
	logic [WIDTH-1:0] link_rx_word;
	logic             link_done_tog;
	// decode and derived
	logic             wr_ctl;
	logic             wr_cfg;
	logic             wr_data;
	logic             wr_rate;
	logic             rd_data;
	logic             slave_active;
	logic             four_wire;
	logic             three_wire;
	logic             done_evt;
	logic [CNT_W-1:0] bit_cnt;
	logic             shift_empty_now;
	logic             load_tx;
	logic             mode_fault;
	logic             link_hold;
	logic             link_rst_n;
	logic             shift_empty_flag;
	logic [7:0]       ctl_view;
	logic [7:0]       cfg_view;

	function automatic logic [CNT_W-1:0] gray_to_bin(input logic [CNT_W-1:0] g);
		logic [CNT_W-1:0] b;
		b[CNT_W-1] = g[CNT_W-1];
		for (int i = CNT_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	assign wr_ctl  = sfr_req.wr && sfr_req.addr == ADDR_CONTROL;
	assign wr_cfg  = sfr_req.wr && sfr_req.addr == ADDR_CONFIG;
	assign wr_data = sfr_req.wr && sfr_req.addr == ADDR_DATA;
	assign wr_rate = sfr_req.wr && sfr_req.addr == ADDR_CLK_RATE;
	assign rd_data = sfr_req.rd && sfr_req.addr == ADDR_DATA;

	assign slave_active    = port_en && !master_en;
	assign four_wire       = sel_mode == SEL_MODE_4WIRE;
	assign three_wire      = sel_mode == SEL_MODE_3WIRE;
	assign done_evt        = done_sync ^ done_prev;
	assign bit_cnt         = gray_to_bin(cnt_sync);
	assign shift_empty_now = !shift_loaded && bit_cnt == '0;
	assign load_tx         = tx_full && (shift_empty_now || done_evt);
	assign mode_fault      = port_en && master_en && four_wire && !sel_sync;
	assign shift_empty_flag = master_en || shift_empty_now;

	// link held idle unless an enabled, selected slave
	assign link_hold  = !port_en || master_en || sel_mode[1]
		|| (four_wire && sel_sync);
	assign link_rst_n = rst_n && !link_hold;

	spi_link_shift #(
		.WIDTH (WIDTH),
		.CNT_W (CNT_W)
	) u_link (
		.sck         (sck_in),
		.edge_invert (pol ^ phase),
		.rst_n       (rst_n),
		.link_rst_n  (link_rst_n),
		.mosi        (mosi_in),
		.cnt_gray    (link_cnt_gray),
		.rx_word     (link_rx_word),
		.done_tog    (link_done_tog)
	);

	// select pin, done toggle and counter into system clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_meta  <= 1'b1;
			sel_sync  <= 1'b1;
			done_meta <= 1'b0;
			done_sync <= 1'b0;
			done_prev <= 1'b0;
			cnt_meta  <= '0;
			cnt_sync  <= '0;
		end else begin
			sel_meta  <= sel_n_in;
			sel_sync  <= sel_meta;
			done_meta <= link_done_tog;
			done_sync <= done_meta;
			done_prev <= done_sync;
			cnt_meta  <= link_cnt_gray;
			cnt_sync  <= cnt_meta;
		end
	end

	// enables, modes and configuration
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_en   <= 1'b0;
			master_en <= 1'b0;
			phase     <= 1'b0;
			pol       <= 1'b0;
			sel_mode  <= SEL_MODE_RESET;
			clk_rate  <= BYTE_RESET;
		end else begin
			if (mode_fault) begin
				port_en   <= 1'b0;
				master_en <= 1'b0;
			end else begin
				if (wr_ctl) port_en <= sfr_req.wdata[CTL_PORT_EN];
				if (wr_cfg) master_en <= sfr_req.wdata[CFG_MASTER];
			end
			if (wr_cfg) begin
				phase <= sfr_req.wdata[CFG_PHASE];
				pol   <= sfr_req.wdata[CFG_POL];
			end
			if (wr_ctl) sel_mode <= sfr_req.wdata[CTL_SEL_HI:CTL_SEL_LO];
			if (wr_rate) clk_rate <= sfr_req.wdata;
		end
	end

	// sticky flags; a set wins over a software clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			transfer_done_flag   <= 1'b0;
			write_collision_flag <= 1'b0;
			mode_fault_flag      <= 1'b0;
			receive_overrun_flag <= 1'b0;
		end else if (wr_ctl) begin
			transfer_done_flag   <= done_evt
				|| (transfer_done_flag && sfr_req.wdata[CTL_DONE]);
			write_collision_flag <= (wr_data && tx_full)
				|| (write_collision_flag && sfr_req.wdata[CTL_WRITE_COLLISION_FLAG]);
			mode_fault_flag      <= mode_fault
				|| (mode_fault_flag && sfr_req.wdata[CTL_MODE_FAULT_FLAG]);
			receive_overrun_flag <= (done_evt && slave_active && rx_full)
				|| (receive_overrun_flag && sfr_req.wdata[CTL_OVRN]);
		end else begin
			transfer_done_flag   <= transfer_done_flag || done_evt;
			write_collision_flag <= write_collision_flag
				|| (wr_data && tx_full);
			mode_fault_flag      <= mode_fault_flag || mode_fault;
			receive_overrun_flag <= receive_overrun_flag
				|| (done_evt && slave_active && rx_full);
		end
	end

	// transmit buffer and shifter load
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf       <= BYTE_RESET;
			tx_full      <= 1'b0;
			tx_shift     <= BYTE_RESET;
			shift_loaded <= 1'b0;
		end else begin
			if (wr_data && !tx_full) begin
				tx_buf  <= sfr_req.wdata;
				tx_full <= 1'b1;
			end else if (load_tx) begin
				tx_full <= 1'b0;
			end
			if (load_tx) begin
				tx_shift     <= tx_buf;
				shift_loaded <= 1'b1;
			end else if (done_evt) begin
				shift_loaded <= 1'b0;
			end
		end
	end

	// receive buffer
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_data <= BYTE_RESET;
			rx_full <= 1'b0;
		end else if (done_evt && slave_active && !rx_full) begin
			rx_data <= link_rx_word;
			rx_full <= 1'b1;
		end else if (rd_data) begin
			rx_full <= 1'b0;
		end
	end

	// status views
	always_comb begin
		ctl_view                        = 8'h00;
		ctl_view[CTL_DONE]              = transfer_done_flag;
		ctl_view[CTL_WRITE_COLLISION_FLAG]              = write_collision_flag;
		ctl_view[CTL_MODE_FAULT_FLAG]              = mode_fault_flag;
		ctl_view[CTL_OVRN]              = receive_overrun_flag;
		ctl_view[CTL_SEL_HI:CTL_SEL_LO] = sel_mode;
		ctl_view[CTL_TX_EMPTY]          = !tx_full;
		ctl_view[CTL_PORT_EN]           = port_en;
		cfg_view                        = 8'h00;
		cfg_view[CFG_BUSY]              = bit_cnt != '0;
		cfg_view[CFG_MASTER]            = master_en;
		cfg_view[CFG_PHASE]             = phase;
		cfg_view[CFG_POL]               = pol;
		cfg_view[CFG_SELECTED]          = !sel_sync;
		cfg_view[CFG_SEL_PIN]           = sel_sync;
		cfg_view[CFG_SHIFT_EMPTY]       = shift_empty_flag;
		cfg_view[CFG_RX_EMPTY]          = !rx_full;
	end

	// register read port
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.rd) begin
			case (sfr_req.addr)
				ADDR_CONTROL:  sfr_rdata <= ctl_view;
				ADDR_CONFIG:   sfr_rdata <= cfg_view;
				ADDR_DATA:     sfr_rdata <= rx_data;
				ADDR_CLK_RATE: sfr_rdata <= clk_rate;
				default:       sfr_rdata <= 8'h00;
			endcase
		end
	end

	// serial output and interrupt request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			miso_out <= 1'b0;
			miso_oe  <= 1'b0;
			irq_req  <= 1'b0;
		end else begin
			miso_out <= tx_shift[~bit_cnt];
			miso_oe  <= slave_active
				&& (three_wire || (four_wire && !sel_sync));
			irq_req  <= transfer_done_flag || write_collision_flag
				|| mode_fault_flag || receive_overrun_flag;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	flag_done_set_a: assert property (done_evt |=> transfer_done_flag)
		else $error("byte done did not set done flag");
	flags_hold_a: assert property (transfer_done_flag && !wr_ctl
		|=> transfer_done_flag)
		else $error("done flag cleared without software write");
	collision_drop_a: assert property (wr_data && tx_full
		|=> write_collision_flag && $stable(tx_buf))
		else $error("collision write not dropped or not flagged");
	overrun_keep_a: assert property (done_evt && slave_active && rx_full
		|=> receive_overrun_flag && $stable(rx_data))
		else $error("overrun did not keep old byte");
	rx_copy_a: assert property (done_evt && slave_active && !rx_full
		|=> rx_full && rx_data == $past(link_rx_word))
		else $error("received byte not copied");
	fault_disable_a: assert property (mode_fault
		|=> mode_fault_flag && !port_en && !master_en)
		else $error("mode fault did not disable port");
	tx_load_now_a: assert property (wr_data && !tx_full && !shift_loaded
		&& bit_cnt == '0 && !done_evt ##1 bit_cnt == '0
		|=> shift_loaded && tx_shift == $past(sfr_req.wdata, 2) && !tx_full)
		else $error("write to empty shifter not loaded at once");
	read_data_a: assert property (rd_data |=> sfr_rdata == $past(rx_data))
		else $error("data read did not return receive buffer");
	slave_hold_a: assert property (master_en || !port_en |-> !link_rst_n)
		else $error("link running outside slave mode");
	busy_view_a: assert property (bit_cnt != '0 |-> cfg_view[CFG_BUSY]
		&& !cfg_view[CFG_SHIFT_EMPTY] || master_en)
		else $error("busy or shift-empty wrong mid byte");

	done_three_wire_c: cover property (done_evt && three_wire && slave_active);
	done_four_wire_c: cover property (done_evt && four_wire && slave_active);
	overrun_c: cover property (done_evt && slave_active && rx_full);
	collision_c: cover property (wr_data && tx_full);
	fault_c: cover property (mode_fault);

endmodule
`default_nettype wire

// *** verif/spi_master_model.sv ***
// model of the external serial master driving clock, select and data
`timescale 1ns/10ps
`default_nettype none
module spi_master_model #(
	parameter int HALF_NS = 105
) (
	// serial pins
	output var logic sck,
	output var logic mosi,
	output var logic sel_n,
	input  wire logic miso
);
	initial begin
		sck = 1'b0;
		mosi = 1'b1;
		sel_n = 1'b1;
	end

	// idle clock level, changed only while the port is disabled
	task automatic set_mode(input logic pol);
		sck = pol;
	endtask

	task automatic set_sel(input logic v);
		sel_n = v;
	endtask

	// one frame of nbits, select driven low when sel is set
	task automatic xfer(input logic ph, input logic sel, input int nbits,
		input logic [7:0] tx, output logic [7:0] rx);
		int i;
		rx = 8'h00;
		sel_n = ~sel;
		#100;
		for (i = 0; i < nbits; i++) begin
			if (ph) begin
				sck = ~sck;
			end
			mosi = tx[7-i];
			#HALF_NS;
			sck = ~sck;
			rx = {rx[6:0], miso};
			#HALF_NS;
			if (!ph) begin
				sck = ~sck;
			end
		end
		#HALF_NS;
		sel_n = 1'b1;
		mosi = ~mosi;
		#HALF_NS;
	endtask
endmodule
`default_nettype wire

// *** verif/tb_spi_port_slave_and_flags.sv ***
// self-checking bench for the serial port slave
`timescale 1ns/10ps
`default_nettype none
module tb_spi_port_slave_and_flags import spi_port_pkg::*;;
	localparam int LIMIT = 20000;
	logic      sys_clk;
	logic      rst_n;
	sfr_req_t  sfr_req;
	logic[7:0] sfr_rdata;
	logic      miso_out;
	logic      miso_oe;
	logic      irq_req;
	logic      miso_last = 1'b0;
	logic[7:0] mrx;
	wire logic sck;
	wire logic mosi;
	wire logic sel_n;
	wire logic miso_w;
	int        n_errors;
	int        tests_run;
	int        cycles;

	spi_port_slave #(.WIDTH(BYTE_BITS), .CNT_W(BIT_CNT_W)) DUT (
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.sfr_req   (sfr_req),
		.sfr_rdata (sfr_rdata),
		.sck_in    (sck),
		.mosi_in   (mosi),
		.sel_n_in  (sel_n),
		.miso_out  (miso_out),
		.miso_oe   (miso_oe),
		.irq_req   (irq_req)
	);

	spi_master_model master (
		.sck   (sck),
		.mosi  (mosi),
		.sel_n (sel_n),
		.miso  (miso_w)
	);

	// released data line shows the inverse of its last value
	always @(miso_out or miso_oe) begin
		if (miso_oe) begin
			miso_last = miso_out;
		end
	end
	assign miso_w = miso_oe ? miso_out : ~miso_last;

	always #10 sys_clk = ~sys_clk;

	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == LIMIT) begin
			n_errors = n_errors + 1;
			finish_test;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_req = {1'b1, 1'b0, a, d};
		@(negedge sys_clk);
		sfr_req = '0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk);
		sfr_req = {1'b0, 1'b1, a, 8'h00};
		@(negedge sys_clk);
		sfr_req = '0;
		chk(sfr_rdata, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic t_reset;
		rchk(ADDR_CONTROL, 8'h06);
		rchk(ADDR_CONFIG, 8'h07);
		rchk(ADDR_CLK_RATE, 8'h00);
		rchk(8'h55, 8'h00);
		chk({7'h00, miso_oe}, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_buffers;
		wr(ADDR_CONTROL, 8'h05);
		wr(ADDR_DATA, 8'hA5);
		idle(2);
		rchk(ADDR_CONTROL, 8'h07);
		wr(ADDR_DATA, 8'h5A);
		rchk(ADDR_CONTROL, 8'h05);
		wr(ADDR_DATA, 8'h77);
		idle(2);
		rchk(ADDR_CONTROL, 8'h45);
		master.xfer(1'b0, 1'b1, 8, 8'h3C, mrx);
		chk(mrx, 8'hA5);
		idle(8);
		rchk(ADDR_CONTROL, 8'hC7);
		chk({7'h00, irq_req}, 8'h01);
		master.xfer(1'b0, 1'b1, 8, 8'h96, mrx);
		chk(mrx, 8'h5A);
		idle(8);
		rchk(ADDR_CONTROL, 8'hD7);
		rchk(ADDR_DATA, 8'h3C);
		wr(ADDR_CONTROL, 8'h05);
		idle(3);
		rchk(ADDR_CONTROL, 8'h07);
		chk({7'h00, irq_req}, 8'h00);
		$display("test buffers done");
	endtask

	task automatic t_modes;
		int i;
		logic [7:0] cfg;
		wr(ADDR_CLK_RATE, 8'h3F);
		for (i = 0; i < 4; i++) begin
			cfg = 8'(i << 4);
			wr(ADDR_CONTROL, 8'h04);
			wr(ADDR_CONFIG, cfg);
			master.set_mode(cfg[4]);
			wr(ADDR_CONTROL, 8'h05);
			wr(ADDR_DATA, 8'hC3 ^ cfg);
			master.xfer(cfg[5], 1'b1, 8, 8'h1E + cfg, mrx);
			chk(mrx, 8'hC3 ^ cfg);
			idle(8);
			rchk(ADDR_CONTROL, 8'h87);
			rchk(ADDR_DATA, 8'h1E + cfg);
			idle(2);
			rchk(ADDR_CONFIG, cfg | 8'h07);
			wr(ADDR_CONTROL, 8'h05);
		end
		wr(ADDR_CONTROL, 8'h04);
		wr(ADDR_CONFIG, 8'h00);
		master.set_mode(1'b0);
		wr(ADDR_CONTROL, 8'h05);
		$display("test modes done");
	endtask

	task automatic t_select;
		master.xfer(1'b0, 1'b0, 8, 8'hFF, mrx);
		idle(8);
		rchk(ADDR_CONTROL, 8'h07);
		chk({7'h00, miso_oe}, 8'h00);
		master.xfer(1'b0, 1'b1, 3, 8'hFF, mrx);
		master.xfer(1'b0, 1'b1, 8, 8'h6B, mrx);
		idle(8);
		rchk(ADDR_DATA, 8'h6B);
		wr(ADDR_CONTROL, 8'h05);
		$display("test select done");
	endtask

	task automatic t_three_wire;
		wr(ADDR_CONTROL, 8'h01);
		rchk(ADDR_CONTROL, 8'h03);
		master.xfer(1'b0, 1'b0, 3, 8'hFF, mrx);
		idle(6);
		rchk(ADDR_CONFIG, 8'h85);
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_CONTROL, 8'h01);
		master.xfer(1'b0, 1'b0, 8, 8'hE4, mrx);
		idle(8);
		rchk(ADDR_DATA, 8'hE4);
		rchk(ADDR_CONTROL, 8'h83);
		wr(ADDR_CONTROL, 8'h01);
		$display("test three wire done");
	endtask

	task automatic t_fault;
		wr(ADDR_CONTROL, 8'h05);
		wr(ADDR_CONFIG, 8'h40);
		master.set_sel(1'b0);
		idle(6);
		rchk(ADDR_CONTROL, 8'h26);
		rchk(ADDR_CONFIG, 8'h0B);
		chk({7'h00, irq_req}, 8'h01);
		master.set_sel(1'b1);
		wr(ADDR_CONTROL, 8'h04);
		idle(3);
		rchk(ADDR_CONTROL, 8'h06);
		$display("test fault done");
	endtask

	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		sfr_req = '0;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		t_reset;
		t_buffers;
		t_modes;
		t_select;
		t_three_wire;
		t_fault;
		finish_test;
	end
endmodule
`default_nettype wire
